/* rtl/opdsc_chan_div.sv */
// Purpose: Channel divider clocked by post-divider ticks.
// Assumes: Divide value is ratio + 1 post-divider periods, or two periods for ratio zero.
// Notes: Hold acts as a synchronous reset that keeps the output static.
`timescale 1ns/1ps
`default_nettype none
module opdsc_chan_div
	import opdsc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic tick_i,
	input wire logic hold_i,
	input wire logic [9:0] ratio_i,
	// Output
	output logic clk_o
);

	logic [9:0] cnt_reg;
	logic [9:0] cnt_next;
	logic [9:0] half;

	assign half = 10'((11'(ratio_i) + 11'h001) >> 1);
	assign cnt_next = (cnt_reg >= ratio_i) ? 10'h000 : cnt_reg + 10'h001;

	////////////////////////////////////////////////////////////////////////
	// Count ticks; sync hold restarts every unmasked channel aligned
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 10'h000;
			clk_o <= 1'b0;
		end else if (hold_i) begin
			cnt_reg <= 10'h000;
			clk_o <= 1'b0;
		end else if (tick_i) begin
			cnt_reg <= cnt_next;
			clk_o <= (ratio_i == 10'h000) ? !clk_o : (cnt_next < half);
		end
	end

endmodule
`default_nettype wire

/* rtl/opdsc_pkg.sv */
// Purpose: Shared constants and types for the post-divider sync control.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes: Single clock domain, the divider input clock.
package opdsc_pkg;

	// Register word indices (byte address = index * 4)
	localparam logic [11:0] IDX_PDIV_RST = 12'h433;
	localparam logic [11:0] IDX_PDIV_RATIO = 12'h434;
	localparam logic [11:0] IDX_SYNC_CFG = 12'h435;
	localparam logic [11:0] IDX_SYNC_MASK = 12'h436;
	localparam logic [11:0] IDX_SYNC_STATUS = 12'h437;
	localparam logic [11:0] IDX_SYNC_CMD = 12'h438;

	// Field positions
	localparam int LF_BYP_BIT = 0;
	localparam int PDIV_RST_BIT = 1;
	localparam int AUTO_LSB = 0;
	localparam int SRC_BIT = 2;
	localparam int CHB_MASK_BIT = 1;
	localparam int APLL_MASK_BIT = 2;
	localparam int MAN_SYNC_BIT = 0;

	// Reset values
	localparam logic [3:0] PDIV_CODE_RST = 4'h0;
	localparam logic [7:0] REG_ZERO = 8'h00;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// Timing: sync pulse width at a 40 MHz divider input clock
	localparam int CLK_PERIOD_PS = 25000;
	localparam int SYNC_PULSE_NS = 100;
	localparam int SYNC_PULSE_CYC_I =
		(SYNC_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] SYNC_PULSE_CYC =
		4'(SYNC_PULSE_CYC_I < 1 ? 1 : SYNC_PULSE_CYC_I);

	// AHB transfer type
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	typedef enum logic [1:0] {
		AUTO_OFF = 2'b00,
		AUTO_FREQ = 2'b01,
		AUTO_PHASE = 2'b10,
		AUTO_RSVD = 2'b11
	} opdsc_auto_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_PULSE = 2'b10
	} opdsc_state_t;

	// Software configuration
	typedef struct packed {
		logic pdiv_rst;
		logic lf_bypass;
		logic [3:0] pdiv_code;
		logic src_ref;
		opdsc_auto_t auto_mode;
		logic apll_mask;
		logic chb_mask;
	} opdsc_cfg_t;

	// Loop status arriving from analog and digital loops
	typedef struct packed {
		logic apll_cal_done;
		logic apll_locked;
		logic digital_loop_freq_lock;
		logic digital_loop_phase_lock;
		logic ref_edge;
	} opdsc_lock_t;

	// Ratio code to divide value; zero marks an undefined code
	function automatic logic [3:0] opdsc_pdiv_ratio(input logic [3:0] code);
		logic [3:0] n;
		n = 4'h0;
		unique case (code)
			4'h2, 4'h3, 4'h5, 4'h6, 4'h7,
			4'h8, 4'h9, 4'hA, 4'hB: n = code;
			default: n = 4'h0;
		endcase
		return n;
	endfunction

endpackage

/* rtl/opdsc_post_div.sv */
// Purpose: Post-divider after the output analog loop VCO.
// Assumes: Ratio is a legal divide value or zero for undefined.
// Notes: Tick marks each divided output period start.
`timescale 1ns/1ps
`default_nettype none
module opdsc_post_div
	import opdsc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic hold_i,
	input wire logic [3:0] ratio_i,
	// Divided output
	output logic tick_o,
	output logic clk_div_o
);

	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic run;

	// Undefined codes park the divider rather than guess a ratio
	assign run = !hold_i && (ratio_i != 4'h0);
	assign cnt_next = (cnt_reg >= ratio_i - 4'h1) ? 4'h0 : cnt_reg + 4'h1;

	////////////////////////////////////////////////////////////////////////
	// Counter, cleared while held in reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 4'h0;
		end else if (!run) begin
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Output clock high for the first half period
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_div_o <= 1'b0;
			tick_o <= 1'b0;
		end else begin
			clk_div_o <= run && (cnt_next < (ratio_i >> 1));
			tick_o <= run && (cnt_next == 4'h0);
		end
	end

endmodule
`default_nettype wire

/* rtl/opdsc_top.sv */
// Purpose: Post-divider and distribution sync control for channel group.
// Assumes: AHB-Lite slave, single word transfers, clk_i is divider input.
// Notes: Lock and reference inputs are asynchronous and synchronised here.
// Notes on behaviour
// - Reset bit one holds post-divider in reset.
// - Ratio code selects divide two, three or five through eleven.
// - Direct source: sync gated only by calibration, lock.
// - Reference source: sync waits next reference edge.
// - Auto field syncs on frequency or phase lock.
// - Unmasked: sync waits for calibration and lock.
// - Masked: lock state ignored for sync.
// - Channel mask releases divider from static sync.
// - Masked channel ignores every sync event.
// - Channel mask never enables output drivers.
`timescale 1ns/1ps
`default_nettype none
module opdsc_top
	import opdsc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Loop status, asynchronous
	input wire opdsc_lock_t lock_i,
	// Channel settings and driver request from the output stage
	input wire logic [9:0] chb_ratio_i,
	input wire logic chb_drv_en_i,
	// Outputs
	output logic pdiv_clk_o,
	output logic lf_zero_bypass_o,
	output logic dist_sync_o,
	output logic chb_clk_o,
	output logic chb_drv_en_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	opdsc_cfg_t cfg_reg;
	opdsc_lock_t lock_s1_reg;
	opdsc_lock_t lock_s2_reg;
	logic ref_d_reg;
	logic freq_d_reg;
	logic phase_d_reg;
	opdsc_state_t state_reg;
	opdsc_state_t state_next;
	logic pending_reg;
	logic hold_reg;
	logic [3:0] pulse_cnt_reg;
	logic man_sync;
	logic auto_evt;
	logic armed;
	logic ref_rise;
	logic fire;
	logic pulse_done;
	logic pdiv_tick;
	logic chb_hold;

	logic ap_valid_reg;
	logic ap_write_reg;
	logic [11:0] ap_idx_reg;
	logic rd_wait_reg;
	logic ap_take;
	logic wr_en;
	logic [7:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// AHB address phase capture
	assign ap_take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_idx_reg <= 12'h000;
		end else if (hready_i || !ap_valid_reg) begin
			ap_valid_reg <= ap_take;
			ap_write_reg <= hwrite_i;
			ap_idx_reg <= haddr_i[13:2];
		end
	end

	// Reads take one wait state so read data comes from a register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_wait_reg <= 1'b0;
		end else begin
			rd_wait_reg <= ap_valid_reg && !ap_write_reg && !rd_wait_reg;
		end
	end

	assign hreadyout_o = !(ap_valid_reg && !ap_write_reg && !rd_wait_reg);
	assign hresp_o = 1'b0;
	assign wr_en = ap_valid_reg && ap_write_reg;

	// Read mux; reserved bits and unmapped words read zero
	always_comb begin
		rd_mux = REG_ZERO;
		unique case (ap_idx_reg)
			IDX_PDIV_RST: begin
				rd_mux[PDIV_RST_BIT] = cfg_reg.pdiv_rst;
				rd_mux[LF_BYP_BIT] = cfg_reg.lf_bypass;
			end
			IDX_PDIV_RATIO: rd_mux[3:0] = cfg_reg.pdiv_code;
			IDX_SYNC_CFG: begin
				rd_mux[SRC_BIT] = cfg_reg.src_ref;
				rd_mux[AUTO_LSB +: 2] = cfg_reg.auto_mode;
			end
			IDX_SYNC_MASK: begin
				rd_mux[APLL_MASK_BIT] = cfg_reg.apll_mask;
				rd_mux[CHB_MASK_BIT] = cfg_reg.chb_mask;
			end
			IDX_SYNC_STATUS: rd_mux = {3'b000, armed, pending_reg,
				hold_reg, state_reg};
			default: rd_mux = REG_ZERO;
		endcase
	end

	// Read data register, loaded in the wait state
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hrdata_o <= RDATA_ZERO;
		end else if (ap_valid_reg && !ap_write_reg && !rd_wait_reg) begin
			hrdata_o <= {24'h00_0000, rd_mux};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers, written in the data phase
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_reg.pdiv_rst <= 1'b0;
			cfg_reg.lf_bypass <= 1'b0;
			cfg_reg.pdiv_code <= PDIV_CODE_RST;
			cfg_reg.src_ref <= 1'b0;
			cfg_reg.auto_mode <= AUTO_OFF;
			cfg_reg.apll_mask <= 1'b0;
			cfg_reg.chb_mask <= 1'b0;
		end else if (wr_en) begin
			unique case (ap_idx_reg)
				IDX_PDIV_RST: begin
					cfg_reg.pdiv_rst <= hwdata_i[PDIV_RST_BIT];
					cfg_reg.lf_bypass <= hwdata_i[LF_BYP_BIT];
				end
				IDX_PDIV_RATIO: cfg_reg.pdiv_code <= hwdata_i[3:0];
				IDX_SYNC_CFG: begin
					cfg_reg.src_ref <= hwdata_i[SRC_BIT];
					cfg_reg.auto_mode <=
						opdsc_auto_t'(hwdata_i[AUTO_LSB +: 2]);
				end
				IDX_SYNC_MASK: begin
					cfg_reg.apll_mask <= hwdata_i[APLL_MASK_BIT];
					cfg_reg.chb_mask <= hwdata_i[CHB_MASK_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Write of one to the command word requests a sync
	assign man_sync = wr_en && (ap_idx_reg == IDX_SYNC_CMD) &&
		hwdata_i[MAN_SYNC_BIT];

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every asynchronous status input
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_s1_reg <= '0;
			lock_s2_reg <= '0;
		end else begin
			lock_s1_reg <= lock_i;
			lock_s2_reg <= lock_s1_reg;
		end
	end

	// Delayed copies for edge detection, taken after the second flop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_d_reg <= 1'b0;
			freq_d_reg <= 1'b0;
			phase_d_reg <= 1'b0;
		end else begin
			ref_d_reg <= lock_s2_reg.ref_edge;
			freq_d_reg <= lock_s2_reg.digital_loop_freq_lock;
			phase_d_reg <= lock_s2_reg.digital_loop_phase_lock;
		end
	end

	assign ref_rise = lock_s2_reg.ref_edge && !ref_d_reg;

	// Auto sync on the selected digital loop lock rising; 11 does nothing
	always_comb begin
		unique case (cfg_reg.auto_mode)
			AUTO_FREQ: auto_evt = lock_s2_reg.digital_loop_freq_lock &&
				!freq_d_reg;
			AUTO_PHASE: auto_evt = lock_s2_reg.digital_loop_phase_lock &&
				!phase_d_reg;
			AUTO_OFF, AUTO_RSVD: auto_evt = 1'b0;
		endcase
	end

	// Armed once calibrated and locked, or always when lock is masked
	assign armed = cfg_reg.apll_mask ||
		(lock_s2_reg.apll_cal_done && lock_s2_reg.apll_locked);

	////////////////////////////////////////////////////////////////////////
	// Sync sequencer
	assign fire = armed && (!cfg_reg.src_ref || ref_rise);
	assign pulse_done = (pulse_cnt_reg == SYNC_PULSE_CYC - 4'h1);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (pending_reg) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (fire) begin
					state_next = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (pulse_done) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_WAIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Pending request; a new request beats the clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pending_reg <= 1'b0;
		end else if (man_sync || auto_evt) begin
			pending_reg <= 1'b1;
		end else if (state_reg == ST_IDLE) begin
			pending_reg <= 1'b0;
		end
	end

	// Pulse width counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_cnt_reg <= 4'h0;
		end else if (state_reg == ST_PULSE) begin
			pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
		end else begin
			pulse_cnt_reg <= 4'h0;
		end
	end

	// Distribution held static from reset until the first sync ends
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_reg <= 1'b1;
		end else if (state_reg == ST_WAIT && fire) begin
			hold_reg <= 1'b1;
		end else if (state_reg == ST_PULSE && pulse_done) begin
			hold_reg <= 1'b0;
		end
	end

	assign dist_sync_o = hold_reg;

	////////////////////////////////////////////////////////////////////////
	// Dividers; mask bit acts at once, bypassing the sequencer
	assign chb_hold = hold_reg && !cfg_reg.chb_mask;

	opdsc_post_div u_post_div (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.hold_i(cfg_reg.pdiv_rst),
		.ratio_i(opdsc_pdiv_ratio(cfg_reg.pdiv_code)),
		.tick_o(pdiv_tick),
		.clk_div_o(pdiv_clk_o)
	);

	opdsc_chan_div u_chb_div (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(pdiv_tick),
		.hold_i(chb_hold),
		.ratio_i(chb_ratio_i),
		.clk_o(chb_clk_o)
	);

	// Driver enable follows the output stage alone, never the mask
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chb_drv_en_o <= 1'b0;
			lf_zero_bypass_o <= 1'b0;
		end else begin
			chb_drv_en_o <= chb_drv_en_i;
			lf_zero_bypass_o <= cfg_reg.lf_bypass;
		end
	end

endmodule
`default_nettype wire

/* testbench/opdsc_assertions.sv */
// Purpose: Port checks for the post-divider sync control.
// Assumes: hready_i is the bus hready, tied to hreadyout_o.
// Notes: Mirrors two config bytes from the observed writes.
`timescale 1ns/1ps
`default_nettype none
module opdsc_assertions
	import opdsc_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// Loop status and outputs
	input wire opdsc_lock_t lock_i,
	input wire logic chb_drv_en_i,
	input wire logic pdiv_clk_o,
	input wire logic dist_sync_o,
	input wire logic chb_clk_o,
	input wire logic chb_drv_en_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic rq, lk, wph, prst, mska, mskb;
	logic [11:0] widx;
	////////////////////////////////////////////////////////////////////
	// Request and lock decode
	assign rq = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
	assign lk = lock_i.apll_cal_done && lock_i.apll_locked;
	// Write mirror; lands at the end of the data phase like the design
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wph <= 1'h0;
			widx <= 12'h000;
		end else if (hready_i) begin
			wph <= rq && hwrite_i;
			widx <= haddr_i[13:2];
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prst <= 1'h0;
			mska <= 1'h0;
			mskb <= 1'h0;
		end else if (wph && hreadyout_o) begin
			if (widx == IDX_PDIV_RST) begin
				prst <= hwdata_i[PDIV_RST_BIT];
			end
			if (widx == IDX_SYNC_MASK) begin
				mska <= hwdata_i[APLL_MASK_BIT];
				mskb <= hwdata_i[CHB_MASK_BIT];
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	property p_hresp; hresp_o == 1'h0; endproperty
	a_hresp: assert property (p_hresp) else $error("hresp not OKAY");
	property p_rd; rq && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
	a_rd: assert property (p_rd) else $error("read wait wrong");
	property p_wr; rq && hwrite_i |=> hreadyout_o; endproperty
	a_wr: assert property (p_wr) else $error("write stalled");
	property p_pw; $rose(dist_sync_o) |-> dist_sync_o[*4] ##[1:2] !dist_sync_o;
	endproperty
	a_pw: assert property (p_pw)
		else $error("sync pulse width wrong");
	property p_hold; dist_sync_o && !mskb |=> !chb_clk_o; endproperty
	a_hold: assert property (p_hold)
		else $error("channel not held by sync");
	property p_arm; $rose(dist_sync_o) && !mska |-> $past(lk, 3); endproperty
	a_arm: assert property (p_arm)
		else $error("sync before lock");
	property p_drv; !$past(chb_drv_en_i) |-> !chb_drv_en_o; endproperty
	a_drv: assert property (p_drv)
		else $error("driver enabled unasked");
	property p_prst; prst && $past(prst, 2) |-> $stable(pdiv_clk_o); endproperty
	a_prst: assert property (p_prst)
		else $error("post-divider ran in reset");
endmodule
bind opdsc_top opdsc_assertions chk_u (.clk_i, .rst_n_i, .hsel_i, .haddr_i,
	.htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o,
	.lock_i, .chb_drv_en_i, .pdiv_clk_o, .dist_sync_o, .chb_clk_o,
	.chb_drv_en_o);
`default_nettype wire

/* testbench/test_opdsc_top.sv */
// Purpose: Self-checking bench for the post-divider sync control.
// Assumes: Lock inputs held steady around each sync request.
// Notes: Edge counters measure divider periods and sync pulses.
`timescale 1ns/1ps
`default_nettype none
module test_opdsc_top
	import opdsc_pkg::*;
;
	logic clk_i, rst_n_i, hwrite_i, chb_drv_en_i;
	logic [1:0] htrans_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rdq;
	logic [9:0] chb_ratio_i;
	opdsc_lock_t lock_i;
	logic hreadyout_o, hresp_o, pdiv_clk_o, lf_zero_bypass_o;
	logic dist_sync_o, chb_clk_o, chb_drv_en_o;
	logic [11:0] rix[5] = '{IDX_PDIV_RST, IDX_PDIV_RATIO, IDX_SYNC_CFG,
		IDX_SYNC_MASK, 12'h439};
	logic [7:0] rmsk[5] = '{8'h03, 8'h0F, 8'h07, 8'h06, 8'h00};
	int n_fail, checks_done, cyc, n_pd, n_cb, n_ds, w;
	logic [31:0] d;
	opdsc_top dut_u (.clk_i, .rst_n_i, .hsel_i(1'h1), .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
		.hrdata_o, .hreadyout_o, .hresp_o, .lock_i, .chb_ratio_i,
		.chb_drv_en_i, .pdiv_clk_o, .lf_zero_bypass_o, .dist_sync_o,
		.chb_clk_o, .chb_drv_en_o);
	////////////////////////////////////////////////////////////////////
	// Clock, edge counters and hang guard
	always #12.5 clk_i = ~clk_i;
	always @(posedge pdiv_clk_o) n_pd++;
	always @(posedge chb_clk_o) n_cb++;
	always @(posedge dist_sync_o) n_ds++;
	always @(posedge clk_i) begin
		chb_drv_en_i <= rst_n_i & 1'($urandom);
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", nm, e, s);
		end
	endtask
	// Readiness sampled at the falling edge, settled before the next rise
	task automatic rdy();
		int n;
		n = 0;
		@(negedge clk_i);
		while (hreadyout_o !== 1'h1 && n < 20) begin
			n++;
			@(negedge clk_i);
		end
		// A slave that never answers counts against the run
		if (n == 20) n_fail++;
		rdq = hrdata_o;
		@(posedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [11:0] ix,
		input logic [31:0] dv);
		haddr_i <= {18'h0, ix, 2'h0};
		hwrite_i <= w;
		htrans_i <= HTRANS_NONSEQ;
		rdy();
		htrans_i <= 2'h0;
		hwdata_i <= dv;
		rdy();
	endtask
	task automatic wt(input int n);
		n_pd = 0;
		n_cb = 0;
		n_ds = 0;
		repeat (n) @(posedge clk_i);
	endtask
	// Waits for a sync pulse and returns how many cycles it stood
	task automatic pulse(output int wd);
		int n;
		n = 0;
		wd = 0;
		@(negedge clk_i);
		while (dist_sync_o !== 1'h1 && n < 30) begin
			n++;
			@(negedge clk_i);
		end
		while (dist_sync_o === 1'h1 && wd < 30) begin
			wd++;
			@(negedge clk_i);
		end
		@(posedge clk_i);
	endtask
	function automatic logic [31:0] exp_pd(input int c);
		return (c == 2 || c == 3 || c > 4) ? 32'h0000_000C : 32'h0000_0000;
	endfunction
	task automatic finish_test();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(31943));
		{clk_i, rst_n_i, hwrite_i, chb_drv_en_i, htrans_i} = '0;
		{haddr_i, hwdata_i, lock_i} = '0;
		chb_ratio_i = 10'($urandom % 4);
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		// Reset values, then random write and read back
		for (int i = 0; i < 5; i++) begin
			bus(1'h0, rix[i], 32'h0);
			chk("reset value", rdq, RDATA_ZERO);
			// Lock mask kept clear so the hold from reset survives
			d = $urandom & (i == 3 ? 32'hFFFF_FFFB : 32'hFFFF_FFFF);
			bus(1'h1, rix[i], d);
			bus(1'h0, rix[i], d);
			chk("read back", rdq, d & {24'h0, rmsk[i]});
			if (i == 0) chk("bypass", lf_zero_bypass_o, d[0]);
			bus(1'h1, rix[i], 32'h0);
		end
		$display("registers done");
		// Held from reset: channel frozen until masked
		bus(1'h1, IDX_PDIV_RATIO, 32'h3);
		wt(40);
		chk("held chan", n_cb, 0);
		bus(1'h1, IDX_SYNC_MASK, 32'h2);
		wt(40);
		chk("masked chan", n_cb != 0, 1);
		bus(1'h1, IDX_SYNC_MASK, 32'h0);
		// Let the edge that applies the hold pass before counting
		wt(1);
		wt(40);
		chk("unmasked chan", n_cb, 0);
		$display("mask done");
		// Sync request waits for calibration and lock
		bus(1'h1, IDX_SYNC_CMD, 32'h1);
		wt(30);
		chk("sync waits", dist_sync_o, 1);
		lock_i <= 5'h18;
		wt(60);
		chk("sync ends", dist_sync_o, 0);
		chk("chan restarts", n_cb != 0, 1);
		bus(1'h1, IDX_SYNC_CMD, 32'h1);
		pulse(w);
		chk("direct width", w, SYNC_PULSE_CYC);
		// Lock ignored once masked
		lock_i <= 5'h00;
		bus(1'h1, IDX_SYNC_CMD, 32'h1);
		wt(30);
		chk("no lock", n_ds, 0);
		bus(1'h1, IDX_SYNC_MASK, 32'h4);
		pulse(w);
		chk("lock masked", w, SYNC_PULSE_CYC);
		bus(1'h0, IDX_SYNC_MASK, 32'h0);
		chk("mask read", rdq, 32'h0000_0004);
		// Reference source waits for a reference edge
		bus(1'h1, IDX_SYNC_CFG, 32'h4);
		bus(1'h1, IDX_SYNC_CMD, 32'h1);
		wt(30);
		chk("no ref edge", n_ds, 0);
		lock_i.ref_edge <= 1'h1;
		pulse(w);
		chk("ref width", w, SYNC_PULSE_CYC);
		$display("sync done");
		// Every automatic mode against both lock kinds
		for (int m = 0; m < 4; m++) begin
			lock_i <= 5'h00;
			bus(1'h1, IDX_SYNC_CFG, 32'(m));
			wt(10);
			lock_i.digital_loop_freq_lock <= 1'h1;
			wt(30);
			chk("auto freq", n_ds, m == 1);
			lock_i.digital_loop_phase_lock <= 1'h1;
			wt(30);
			chk("auto phase", n_ds, m == 2);
		end
		$display("auto done");
		// Ratio codes zero to eleven, reset pulsed after each change
		for (int c = 0; c < 12; c++) begin
			chb_ratio_i <= 10'($urandom % 4);
			bus(1'h1, IDX_PDIV_RATIO, 32'(c));
			bus(1'h1, IDX_PDIV_RST, 32'h2);
			bus(1'h1, IDX_PDIV_RST, 32'h0);
			wt(8);
			wt(12 * (c < 5 ? 5 : c) / (c < 5 ? 5 : 1) * (c < 5 ? c : 1));
			if (c > 4) chk("ratio", n_pd, exp_pd(c));
		end
		for (int c = 0; c < 5; c++) begin
			bus(1'h1, IDX_PDIV_RATIO, 32'(c));
			// Restart aligned so the window holds whole periods
			bus(1'h1, IDX_PDIV_RST, 32'h2);
			bus(1'h1, IDX_PDIV_RST, 32'h0);
			wt(8);
			wt(60);
			chk("short ratio", n_pd, c < 2 || c == 4 ? 0 : 60 / c);
		end
		bus(1'h1, IDX_PDIV_RST, 32'h2);
		wt(40);
		chk("div reset", n_pd, 0);
		$display("divider done");
		finish_test();
	end
endmodule
`default_nettype wire
